// *** rtl/bpj_defines.svh ***
// Overview of operation
// - external data move takes 2 machine cycles; 8- or 16-bit address
// - accumulator is sole source or destination of external data
// - external read/write strobes idle except during an external data move
// - code constant reads only read program memory, via program strobe
// - pair-based code read fetches byte at accumulator plus pair, 2 cycles
// - counter-based code read adds accumulator to next-instruction address
// - bit addresses 00h-7fh hit lower RAM bits, 80h-ffh hit SFR space
// - every bit operand is a direct bit address carried in the instruction
// - each port line is individually bit-addressable as a one-bit port
// - carry is the Boolean accumulator and also has its own bit address
// - all status flag bits are bit-addressable and testable by bit jumps
// - AND/OR of carry with bit or inverted bit; no exclusive-OR
// - moving carry to a port bit sets its latch to carry; line driven low only for carry 0
// - carry-set, bit-set, test-clear jump on one; clear jumps on zero
// - test-clear jump on a set bit both branches and clears the bit
// - relative branch adds signed offset to next address, only when taken
// - short relative jump is two bytes: opcode then offset
// - long absolute jump is three bytes with a 16-bit destination
// - page jump replaces low 11 address bits, keeps high 5 bits
// - indirect jump loads program counter with pair plus accumulator
// - one machine cycle spans 12 oscillator periods
// - no program fetch in the second cycle of an external data move
`ifndef BPJ_DEFINES_SVH
`define BPJ_DEFINES_SVH

`define BPJ_OSC_PER_MC 12
`define BPJ_PH_END     3'h5
`define BPJ_STB_ON     3'h1
`define BPJ_STB_OFF    3'h4
`define BPJ_RST_PC     16'h0000
`define BPJ_RST_PORT   8'hff
`define BPJ_XA_PAGE    8'h00
`define BPJ_SFR_PORT   5'h12
`define BPJ_SFR_FLAGS  5'h1a
`define BPJ_SFR_ACC    5'h1c
`define BPJ_CY_POS     3'h7
`define BPJ_PAR_POS    3'h0

`define BPJ_OP_XRD_PAIR 8'he0
`define BPJ_OP_XRD_R0   8'he2
`define BPJ_OP_XRD_R1   8'he3
`define BPJ_OP_XWR_PAIR 8'hf0
`define BPJ_OP_XWR_R0   8'hf2
`define BPJ_OP_XWR_R1   8'hf3
`define BPJ_OP_CODE_PR  8'h93
`define BPJ_OP_CODE_PC  8'h83
`define BPJ_OP_AND_C    8'h82
`define BPJ_OP_AND_NC   8'hb0
`define BPJ_OP_OR_C     8'h72
`define BPJ_OP_OR_NC    8'ha0
`define BPJ_OP_BIT_TO_C 8'ha2
`define BPJ_OP_C_TO_BIT 8'h92
`define BPJ_OP_CLR_C    8'hc3
`define BPJ_OP_CLR_BIT  8'hc2
`define BPJ_OP_SET_C    8'hd3
`define BPJ_OP_SET_BIT  8'hd2
`define BPJ_OP_INV_C    8'hb3
`define BPJ_OP_INV_BIT  8'hb2
`define BPJ_OP_JMP_CY   8'h40
`define BPJ_OP_JMP_NCY  8'h50
`define BPJ_OP_JMP_BIT  8'h20
`define BPJ_OP_JMP_NBIT 8'h30
`define BPJ_OP_JMP_TCLR 8'h10
`define BPJ_OP_JMP_REL  8'h80
`define BPJ_OP_JMP_LONG 8'h02
`define BPJ_OP_JMP_IND  8'h73
`define BPJ_PAGE_LOW    5'h01
`define BPJ_OP_LD_ACC   8'h74
`define BPJ_OP_LD_PAIR  8'h90
`define BPJ_OP_LD_R0    8'h78
`define BPJ_OP_LD_R1    8'h79

`endif

// *** rtl/bpj_pkg.sv ***
package bpj_pkg;

  // half-machine-cycle bus slots of one instruction
  typedef enum logic [1:0] {
    SL_OP   = 2'b00,
    SL_B2   = 2'b01,
    SL_B3   = 2'b10,
    SL_LAST = 2'b11
  } bpj_slot_e;

  // what the bus does in a slot
  typedef enum logic [1:0] {
    ACT_FETCH = 2'b00,
    ACT_DUMMY = 2'b01,
    ACT_CODE  = 2'b10,
    ACT_XDATA = 2'b11
  } bpj_act_e;

  typedef struct packed {
    bpj_slot_e    slot;
    logic [2:0]   ph;
    logic [4:0]   ic;
    logic [15:0]  pc;
    logic [7:0]   op;
    logic [7:0]   b2;
    logic [7:0]   b3;
    logic [7:0]   cb;
    logic [7:0]   acc;
    logic         cy;
    logic [6:1]   fl;
    logic [15:0]  dpair;
    logic [7:0]   r0;
    logic [7:0]   r1;
    logic [127:0] bram;
    logic [7:0]   p1;
    logic [15:0]  pa;
    logic         prd_n;
    logic [15:0]  xa;
    logic [7:0]   xw;
    logic         xrd_n;
    logic         xwr_n;
    logic [7:0]   pd1;
    logic [7:0]   pd2;
    logic [7:0]   xd1;
    logic [7:0]   xd2;
    logic [7:0]   pi1;
    logic [7:0]   pi2;
  } bpj_state_s;

endpackage

// *** rtl/bpj_core.sv ***
`timescale 1ns/1ns
`include "bpj_defines.svh"

module bpj_core
  import bpj_pkg::*;
#(
  parameter int BIT_RAM_N = 128
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  output logic [15:0]      PROG_ADDR_O,
  output logic             PROG_READ_STROBE_N_O,
  input  wire logic [7:0]  PROG_DATA_I,
  output logic [15:0]      XDATA_ADDR_O,
  output logic [7:0]       XDATA_WDATA_O,
  input  wire logic [7:0]  XDATA_RDATA_I,
  output logic             XDATA_RD_N_O,
  output logic             XDATA_WR_N_O,
  output logic [7:0]       PORT_O,
  output logic [7:0]       PORT_OE_O,
  input  wire logic [7:0]  PORT_I,
  output logic [7:0]       ACC_O,
  output logic             CARRY_O
);

  if (BIT_RAM_N != 128) begin : g_chk
    $error("bit RAM must hold exactly 128 bits");
  end

  bpj_state_s s_q;
  bpj_state_s s_d;

  function automatic logic is_xd(input logic [7:0] o);
    return (o == `BPJ_OP_XRD_PAIR) || (o == `BPJ_OP_XRD_R0) ||
           (o == `BPJ_OP_XRD_R1) || (o == `BPJ_OP_XWR_PAIR) ||
           (o == `BPJ_OP_XWR_R0) || (o == `BPJ_OP_XWR_R1);
  endfunction

  function automatic logic is_cr(input logic [7:0] o);
    return (o == `BPJ_OP_CODE_PR) || (o == `BPJ_OP_CODE_PC);
  endfunction

  // instruction length in bytes
  function automatic logic [1:0] op_bytes(input logic [7:0] o);
    logic [1:0] n;
    n = 2'h1;
    case (o)
      `BPJ_OP_JMP_REL, `BPJ_OP_AND_C, `BPJ_OP_AND_NC, `BPJ_OP_OR_C,
      `BPJ_OP_OR_NC, `BPJ_OP_BIT_TO_C, `BPJ_OP_C_TO_BIT,
      `BPJ_OP_CLR_BIT, `BPJ_OP_SET_BIT, `BPJ_OP_INV_BIT,
      `BPJ_OP_JMP_CY, `BPJ_OP_JMP_NCY, `BPJ_OP_LD_ACC,
      `BPJ_OP_LD_R0, `BPJ_OP_LD_R1: n = 2'h2;
      `BPJ_OP_JMP_LONG, `BPJ_OP_LD_PAIR, `BPJ_OP_JMP_BIT,
      `BPJ_OP_JMP_NBIT, `BPJ_OP_JMP_TCLR: n = 2'h3;
      default: n = 2'h1;
    endcase
    if (o[4:0] == `BPJ_PAGE_LOW) n = 2'h2;
    return n;
  endfunction

  // two machine cycles or one
  function automatic logic two_mc(input logic [7:0] o);
    logic t;
    t = is_xd(o) || is_cr(o);
    case (o)
      `BPJ_OP_AND_C, `BPJ_OP_AND_NC, `BPJ_OP_OR_C, `BPJ_OP_OR_NC,
      `BPJ_OP_C_TO_BIT, `BPJ_OP_JMP_CY, `BPJ_OP_JMP_NCY,
      `BPJ_OP_JMP_BIT, `BPJ_OP_JMP_NBIT, `BPJ_OP_JMP_TCLR,
      `BPJ_OP_JMP_REL, `BPJ_OP_JMP_LONG, `BPJ_OP_JMP_IND,
      `BPJ_OP_LD_PAIR: t = 1'b1;
      default: t = t;
    endcase
    if (o[4:0] == `BPJ_PAGE_LOW) t = 1'b1;
    return t;
  endfunction

  function automatic bpj_slot_e last_slot(input logic [7:0] o);
    return two_mc(o) ? SL_LAST : SL_B2;
  endfunction

  // bus use of each slot; opcode slot always fetches
  function automatic bpj_act_e slot_act(input bpj_slot_e sl,
                                        input logic [7:0] o);
    bpj_act_e a;
    a = ACT_DUMMY;
    unique case (sl)
      SL_OP:   a = ACT_FETCH;
      SL_B2:   a = (op_bytes(o) > 2'h1) ? ACT_FETCH : ACT_DUMMY;
      SL_B3:   a = is_xd(o) ? ACT_XDATA : is_cr(o) ? ACT_CODE :
                   (op_bytes(o) == 2'h3) ? ACT_FETCH : ACT_DUMMY;
      SL_LAST: a = is_xd(o) ? ACT_XDATA : ACT_DUMMY;
    endcase
    return a;
  endfunction

  // bit space split on address bit 7
  function automatic logic bit_rd(input bpj_state_s s,
                                  input logic [7:0] a,
                                  input logic rmw);
    logic [7:0] by;
    by = 8'h00;
    if (!a[7]) return s.bram[a[6:0]];
    case (a[7:3])
      // port read: pin, or latch for read-modify-write
      `BPJ_SFR_PORT:  by = rmw ? s.p1 : s.pi2;
      // every flag bit, parity from accumulator
      `BPJ_SFR_FLAGS: by = {s.cy, s.fl, ^s.acc};
      `BPJ_SFR_ACC:   by = s.acc;
      default:        by = 8'h00;
    endcase
    return by[a[2:0]];
  endfunction

  function automatic logic [15:0] sext(input logic [7:0] r);
    return {{8{r[7]}}, r};
  endfunction

  bpj_act_e  act;
  bpj_act_e  nact;
  logic      commit;
  logic      bv;
  logic      wr;
  logic      wv;
  logic      tk;
  logic      win;
  logic [7:0] ba;

  // current slot use and end-of-instruction strike
  assign act    = slot_act(s_q.slot, s_q.op);
  assign commit = (s_q.ph == `BPJ_PH_END) &&
                  (s_q.slot == last_slot(s_q.op));

  // sequencer, fetch capture, execution and bus outputs
  always_comb begin
    s_d = s_q;
    bv  = 1'b0;
    wr  = 1'b0;
    wv  = 1'b0;
    tk  = 1'b0;
    win = 1'b0;
    ba  = 8'h00;
    nact = ACT_DUMMY;
    // pins pass two flops before use
    s_d.pd1 = PROG_DATA_I;
    s_d.pd2 = s_q.pd1;
    s_d.xd1 = XDATA_RDATA_I;
    s_d.xd2 = s_q.xd1;
    s_d.pi1 = PORT_I;
    s_d.pi2 = s_q.pi1;
    s_d.ic  = s_q.ic + 5'h01;
    s_d.ph  = s_q.ph + 3'h1;
    if (s_q.ph == `BPJ_PH_END) begin
      // six phases per slot, two slots per machine cycle
      s_d.ph = 3'h0;
      if (act == ACT_FETCH) begin
        s_d.pc = s_q.pc + 16'h0001;
        unique case (s_q.slot)
          SL_OP:   s_d.op = s_q.pd2;
          SL_B2:   s_d.b2 = s_q.pd2;
          SL_B3:   s_d.b3 = s_q.pd2;
          SL_LAST: s_d.b3 = s_q.pd2;
        endcase
      end
      if (act == ACT_CODE) begin
        s_d.cb = s_q.pd2;
      end
      s_d.slot = bpj_slot_e'(s_q.slot + 2'h1);
    end
    if (commit) begin
      s_d.slot = SL_OP;
      s_d.ic   = 5'h00;
      // bit operand always the direct byte b2
      ba = s_d.b2;
      bv = bit_rd(s_q, ba, (s_d.op == `BPJ_OP_INV_BIT) ||
                           (s_d.op == `BPJ_OP_JMP_TCLR));
      case (s_d.op)
        `BPJ_OP_LD_ACC:  s_d.acc = s_d.b2;
        `BPJ_OP_LD_PAIR: s_d.dpair = {s_d.b2, s_d.b3};
        `BPJ_OP_LD_R0:   s_d.r0 = s_d.b2;
        `BPJ_OP_LD_R1:   s_d.r1 = s_d.b2;
        // read data lands only in accumulator
        `BPJ_OP_XRD_PAIR, `BPJ_OP_XRD_R0, `BPJ_OP_XRD_R1:
          s_d.acc = s_q.xd2;
        `BPJ_OP_CODE_PR, `BPJ_OP_CODE_PC: s_d.acc = s_q.cb;
        // and/or with bit or its inverse
        `BPJ_OP_AND_C:   s_d.cy = s_q.cy & bv;
        `BPJ_OP_AND_NC:  s_d.cy = s_q.cy & ~bv;
        `BPJ_OP_OR_C:    s_d.cy = s_q.cy | bv;
        `BPJ_OP_OR_NC:   s_d.cy = s_q.cy | ~bv;
        `BPJ_OP_BIT_TO_C: s_d.cy = bv;
        `BPJ_OP_CLR_C:   s_d.cy = 1'b0;
        `BPJ_OP_SET_C:   s_d.cy = 1'b1;
        `BPJ_OP_INV_C:   s_d.cy = ~s_q.cy;
        `BPJ_OP_C_TO_BIT: begin
          wr = 1'b1;
          wv = s_q.cy;
        end
        `BPJ_OP_CLR_BIT: wr = 1'b1;
        `BPJ_OP_SET_BIT: begin
          wr = 1'b1;
          wv = 1'b1;
        end
        `BPJ_OP_INV_BIT: begin
          wr = 1'b1;
          wv = ~bv;
        end
        // jump senses on carry and bit
        `BPJ_OP_JMP_CY:   tk = s_q.cy;
        `BPJ_OP_JMP_NCY:  tk = ~s_q.cy;
        `BPJ_OP_JMP_BIT:  tk = bv;
        `BPJ_OP_JMP_NBIT: tk = ~bv;
        `BPJ_OP_JMP_TCLR: begin
          tk = bv;
          wr = bv;
        end
        `BPJ_OP_JMP_REL:  tk = 1'b1;
        `BPJ_OP_JMP_LONG: s_d.pc = {s_d.b2, s_d.b3};
        `BPJ_OP_JMP_IND:  s_d.pc = s_q.dpair + {8'h00, s_q.acc};
        default: begin
          // page jump keeps high 5 bits
          if (s_d.op[4:0] == `BPJ_PAGE_LOW) begin
            s_d.pc = {s_d.pc[15:11], s_d.op[7:5], s_d.b2};
          end
        end
      endcase
      // signed offset from next address, only if taken
      if (tk) begin
        // untaken jump leaves pc at next instruction
        s_d.pc = s_d.pc + sext((op_bytes(s_d.op) == 2'h3) ?
                               s_d.b3 : s_d.b2);
      end
      if (wr) begin
        if (!ba[7]) begin
          s_d.bram[ba[6:0]] = wv;
        end else begin
          case (ba[7:3])
            // single port line as its own port
            `BPJ_SFR_PORT: s_d.p1[ba[2:0]] = wv;
            `BPJ_SFR_FLAGS: begin
              // carry through its own bit address
              if (ba[2:0] == `BPJ_CY_POS) s_d.cy = wv;
              else if (ba[2:0] != `BPJ_PAR_POS) s_d.fl[ba[2:0]] = wv;
            end
            `BPJ_SFR_ACC: s_d.acc[ba[2:0]] = wv;
            default: s_d.acc = s_d.acc;
          endcase
        end
      end
    end
    // bus outputs prepared one cycle ahead so they leave flops
    nact = slot_act(s_d.slot, s_d.op);
    if (s_d.ph == 3'h0) begin
      s_d.pa = s_d.pc;
      // pc already points past this opcode
      if (nact == ACT_CODE) begin
        s_d.pa = ((s_d.op == `BPJ_OP_CODE_PR) ? s_d.dpair : s_d.pc) +
                 {8'h00, s_d.acc};
      end
      if (nact == ACT_XDATA && s_d.slot == SL_B3) begin
        // 8-bit pointer or 16-bit pair address
        s_d.xa = s_d.op[1] ?
                 {`BPJ_XA_PAGE, s_d.op[0] ? s_d.r1 : s_d.r0} : s_d.dpair;
        s_d.xw = s_d.acc;
      end
    end
    // code reads use the program strobe, never a write
    s_d.prd_n = !((nact != ACT_XDATA) && (s_d.ph >= `BPJ_STB_ON) &&
                  (s_d.ph <= `BPJ_STB_OFF));
    // strobe spans both slots; data sampled before release
    win = (nact == ACT_XDATA) &&
          ((s_d.slot == SL_B3 && s_d.ph >= `BPJ_STB_ON) ||
           (s_d.slot == SL_LAST && s_d.ph <= `BPJ_STB_OFF));
    // data strobes only inside an external move
    s_d.xrd_n = !(win && !s_d.op[4]);
    s_d.xwr_n = !(win && s_d.op[4]);
  end

  // single state register
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_q       <= '0;
      s_q.pc    <= `BPJ_RST_PC;
      s_q.pa    <= `BPJ_RST_PC;
      s_q.p1    <= `BPJ_RST_PORT;
      s_q.prd_n <= 1'b1;
      s_q.xrd_n <= 1'b1;
      s_q.xwr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // every pin comes straight off a state flop, except PORT_OE_O, which is the inverted port latch
  assign PROG_ADDR_O          = s_q.pa;
  assign PROG_READ_STROBE_N_O = s_q.prd_n;
  assign XDATA_ADDR_O         = s_q.xa;
  assign XDATA_WDATA_O        = s_q.xw;
  assign XDATA_RD_N_O         = s_q.xrd_n;
  assign XDATA_WR_N_O         = s_q.xwr_n;
  assign PORT_O               = s_q.p1;
  assign PORT_OE_O            = ~s_q.p1;  // open drain: drive lows only
  assign ACC_O                = s_q.acc;
  assign CARRY_O              = s_q.cy;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  // instruction lengths in oscillator periods
  xdata_len_a: assert property (commit && is_xd(s_q.op) |->
    s_q.ic == 5'(2 * `BPJ_OSC_PER_MC - 1))
    else $error("external move not two machine cycles");
  mc_bound_a: assert property (commit |->
    s_q.ic == 5'(`BPJ_OSC_PER_MC - 1) ||
    s_q.ic == 5'(2 * `BPJ_OSC_PER_MC - 1))
    else $error("instruction not whole machine cycles");
  acc_wdata_a: assert property (!XDATA_WR_N_O |->
    XDATA_WDATA_O == ACC_O)
    else $error("write data differs from accumulator");
  strobe_idle_a: assert property ((!XDATA_RD_N_O || !XDATA_WR_N_O) |->
    is_xd(s_q.op) && (s_q.slot == SL_B3 || s_q.slot == SL_LAST))
    else $error("data strobe outside external move");
  no_fetch_a: assert property (is_xd(s_q.op) && s_q.slot == SL_LAST |->
    PROG_READ_STROBE_N_O)
    else $error("program fetch during data cycle");
  code_only_a: assert property (is_cr(s_q.op) |-> XDATA_WR_N_O)
    else $error("code read produced a write");
  table_addr_a: assert property (!PROG_READ_STROBE_N_O &&
    s_q.op == `BPJ_OP_CODE_PR && s_q.slot == SL_B3 |->
    PROG_ADDR_O == 16'(s_q.dpair + {8'h00, s_q.acc}))
    else $error("table address not pair plus accumulator");
  rel_jump_a: assert property (commit && s_q.op == `BPJ_OP_JMP_REL |=>
    s_q.pc == 16'($past(s_q.pc) + sext($past(s_q.b2))))
    else $error("relative jump target wrong");
  page_jump_a: assert property (commit &&
    s_q.op[4:0] == `BPJ_PAGE_LOW |=>
    s_q.pc == {$past(s_q.pc[15:11]), $past(s_q.op[7:5]), $past(s_q.b2)})
    else $error("page jump target wrong");
  tclr_bit_a: assert property (commit && s_q.op == `BPJ_OP_JMP_TCLR &&
    !s_q.b2[7] && s_q.bram[s_q.b2[6:0]] |=>
    !s_q.bram[$past(s_q.b2[6:0])] &&
    s_q.pc == 16'($past(s_q.pc) + sext($past(s_q.b3))))
    else $error("test-clear jump did not clear and branch");
  port_carry_a: assert property (commit &&
    s_q.op == `BPJ_OP_C_TO_BIT && s_q.b2[7:3] == `BPJ_SFR_PORT |=>
    PORT_O[$past(s_q.b2[2:0])] == $past(s_q.cy))
    else $error("port line differs from carry");

  xrd_c: cover property (commit && s_q.op == `BPJ_OP_XRD_PAIR);
  table_c: cover property (commit && s_q.op == `BPJ_OP_CODE_PC);
  tclr_c: cover property (commit && s_q.op == `BPJ_OP_JMP_TCLR && tk);
  page_c: cover property (commit && s_q.op[4:0] == `BPJ_PAGE_LOW);

endmodule // bpj_core

// *** testbench/bpj_mem_model.sv ***
`timescale 1ns/1ns
module bpj_mem_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] prog_addr_i,
  input  wire logic        prog_rd_n_i,
  output logic [7:0]       prog_data_o,
  input  wire logic [15:0] xaddr_i,
  input  wire logic [7:0]  xwdata_i,
  input  wire logic        xrd_n_i,
  input  wire logic        xwr_n_i,
  output logic [7:0]       xrdata_o
);
  logic [7:0] prog [0:65535];
  logic [7:0] xram [0:65535];
  logic [7:0] plast_q = 8'h00;
  logic [7:0] xlast_q = 8'h00;
  logic [3:0] xcnt_q  = 4'h0;

  // data only inside the strobe; released lines show the inverse
  // program store has no write path at all
  always_comb begin
    prog_data_o = prog_rd_n_i ? ~plast_q : prog[prog_addr_i];
    if (xrd_n_i || (slow_i && xcnt_q < 4'h5))
      xrdata_o = ~xlast_q; // slow mode answers late in the window
    else
      xrdata_o = xram[xaddr_i];
  end

  // writes taken only while the write strobe is low
  always_ff @(posedge clk_i) begin
    if (!prog_rd_n_i) plast_q <= prog[prog_addr_i];
    xcnt_q <= xrd_n_i ? 4'h0 : xcnt_q + 4'h1;
    if (!xrd_n_i) xlast_q <= xrdata_o;
    if (!xwr_n_i) xram[xaddr_i] <= xwdata_i;
  end
endmodule // bpj_mem_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  ext_port = 8'hff;
  wire  [15:0] paddr, xaddr;
  wire  [7:0]  pdata, xw, xr, port_o, port_oe, acc, pin;
  wire         prd_n, xrd_n, xwr_n, cy;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          xlow = 0;
  int          ovl = 0;
  logic [7:0]  pq[$];

  // 4 ns core clock
  always #2 clk = ~clk;
  // open drain: a driven line pulls low, else the outside level
  assign pin = ext_port & ~port_oe;

  bpj_core u_bpj_core (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .PROG_ADDR_O(paddr),
    .PROG_READ_STROBE_N_O(prd_n), .PROG_DATA_I(pdata),
    .XDATA_ADDR_O(xaddr), .XDATA_WDATA_O(xw), .XDATA_RDATA_I(xr),
    .XDATA_RD_N_O(xrd_n), .XDATA_WR_N_O(xwr_n), .PORT_O(port_o),
    .PORT_OE_O(port_oe), .PORT_I(pin), .ACC_O(acc), .CARRY_O(cy));

  bpj_mem_model u_bpj_mem_model (
    .clk_i(clk), .slow_i(slow), .prog_addr_i(paddr),
    .prog_rd_n_i(prd_n), .prog_data_o(pdata), .xaddr_i(xaddr),
    .xwdata_i(xw), .xrd_n_i(xrd_n), .xwr_n_i(xwr_n), .xrdata_o(xr));

  // strobe activity monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!xrd_n || !xwr_n) xlow <= xlow + 1;
    if ((!xrd_n || !xwr_n) && !prd_n) ovl <= ovl + 1;
    if (cyc == 10000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // hold reset; fill code space with a marker opcode so runaways show
  task automatic prep();
    @(posedge clk);
    rst_b    <= 1'b0;
    slow     <= 1'b0;
    ext_port <= 8'hff;
    for (int i = 0; i < 65536; i++) u_bpj_mem_model.prog[i] = 8'h74;
    repeat (16) @(posedge clk);
  endtask

  task automatic ld(input logic [15:0] base);
    foreach (pq[i]) u_bpj_mem_model.prog[base + 16'(i)] = pq[i];
  endtask

  // program ends in a self loop, so a long wait is safe
  task automatic go();
    xlow = 0;
    ovl = 0;
    rst_b <= 1'b1;
    repeat (600) @(posedge clk);
    #1;
  endtask

  // all six move forms with a slow memory
  task automatic t_xdata();
    prep();
    u_bpj_mem_model.xram[16'h0023] = 8'h3c;
    slow <= 1'b1;
    pq = '{8'h90, 8'h01, 8'h23, 8'h74, 8'ha5, 8'hf0, 8'h78, 8'h23,
           8'he2, 8'h79, 8'h45, 8'hf3, 8'he0, 8'h78, 8'h46, 8'hf2,
           8'he3, 8'h80, 8'hfe};
    ld(16'h0000);
    go();
    chk("xram 0123", 16'h00a5, {8'h00, u_bpj_mem_model.xram[16'h0123]});
    chk("xram 0045", 16'h003c, {8'h00, u_bpj_mem_model.xram[16'h0045]});
    chk("xram 0046", 16'h00a5, {8'h00, u_bpj_mem_model.xram[16'h0046]});
    chk("acc after read", 16'h003c, {8'h00, acc});
    chk("pointer address", 16'h0045, xaddr);
    chk("strobe cycles", 16'h003c, xlow[15:0]);
    chk("fetch overlap", 16'h0000, ovl[15:0]);
  endtask

  // table read with carry into the high byte
  task automatic t_code_pair();
    prep();
    pq = '{8'h90, 8'h00, 8'hfe, 8'h74, 8'hff, 8'h93, 8'h80, 8'hfe};
    ld(16'h0000);
    pq = '{8'hc7};
    ld(16'h01fd);
    go();
    chk("pair table acc", 16'h00c7, {8'h00, acc});
    chk("no data strobe", 16'h0000, xlow[15:0]);
  endtask

  // index zero returns the following opcode
  task automatic t_code_pc();
    prep();
    pq = '{8'h74, 8'h00, 8'h83, 8'h80, 8'hfe};
    ld(16'h0000);
    go();
    chk("pc table acc", 16'h0080, {8'h00, acc});
  endtask

  // carry logic, port bits, flag bit address
  task automatic t_bool();
    prep();
    ext_port <= 8'hf7;
    pq = '{8'ha2, 8'h93, 8'h92, 8'h91, 8'ha0, 8'h93, 8'hc2, 8'h92,
           8'h92, 8'h92, 8'hd2, 8'h05, 8'hb0, 8'h05, 8'h72, 8'h05,
           8'h82, 8'h06, 8'hb3, 8'hb2, 8'hd7, 8'h92, 8'h90, 8'hd3,
           8'h80, 8'hfe};
    ld(16'h0000);
    go();
    chk("port latch", 16'h00fc, {8'h00, port_o});
    chk("port enable", 16'h0003, {8'h00, port_oe});
    chk("carry", 16'h0001, {15'h0, cy});
  endtask

  // bit jumps taken and not taken
  task automatic t_bitjmp();
    prep();
    pq = '{8'hd2, 8'h7f, 8'h10, 8'h7f, 8'h02, 8'h74, 8'h11, 8'h20,
           8'h7f, 8'h02, 8'h74, 8'h01, 8'h30, 8'h7f, 8'h02, 8'h74,
           8'h33, 8'h20, 8'hd0, 8'h02, 8'h74, 8'h44, 8'hc3, 8'h40,
           8'h02, 8'h50, 8'h02, 8'h74, 8'h55, 8'h80, 8'hfe};
    ld(16'h0000);
    go();
    chk("bit jump path", 16'h0001, {8'h00, acc});
  endtask

  task automatic t_jump();
    prep();
    pq = '{8'h02, 8'h01, 8'h00};
    ld(16'h0000);
    pq = '{8'h61, 8'h23};
    ld(16'h0100);
    pq = '{8'h90, 8'h02, 8'h00, 8'h74, 8'h10, 8'h73};
    ld(16'h0323);
    pq = '{8'h80, 8'hf0};
    ld(16'h0210);
    pq = '{8'h74, 8'h5a, 8'h80, 8'hfe};
    ld(16'h0202);
    go();
    chk("jump chain acc", 16'h005a, {8'h00, acc});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    t_xdata();
    t_code_pair();
    t_code_pc();
    t_bool();
    t_bitjmp();
    t_jump();
    wrap_up();
  end
endmodule // tb_top
